// >>> ubo_pkg.sv
// constants and types shared by the unbanded transfer order writer
package ubo_pkg;

	// ****************************************
	// order encodings placed in the display list
	// ****************************************
	localparam logic [7:0] OP_PLAIN = 8'h22; // plain source/destination
	localparam logic [7:0] OP_HALF = 8'h23; // source/halftone/destination
	localparam logic [7:0] OP_EXP = 8'h26; // expanded source/destination
	localparam logic [7:0] OP_RSVD = 8'h00; // reserved byte after opcode

	// parameter list lengths in 16-bit words, opcode word included
	localparam logic [3:0] WORDS_PLAIN = 4'h7;
	localparam logic [3:0] WORDS_HALF = 4'hB;
	localparam logic [3:0] WORDS_EXP = 4'h9;

	// ****************************************
	// register offsets (byte addresses, one word each)
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_DEST = 8'h08;
	localparam logic [7:0] REG_FRAME = 8'h0C;
	localparam logic [7:0] REG_SRC = 8'h10;
	localparam logic [7:0] REG_SWARP = 8'h14;
	localparam logic [7:0] REG_SCALE = 8'h18;
	localparam logic [7:0] REG_HREM = 8'h1C;
	localparam logic [7:0] REG_HADDR = 8'h20;
	localparam logic [7:0] REG_HDIM = 8'h24;
	localparam logic [7:0] REG_SDIM = 8'h28;
	localparam logic [7:0] REG_LPTR = 8'h2C;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_GO = 4; // write one to start an order
	localparam int CTRL_UBSET = 8; // destination setup already issued
	localparam int CTRL_HTSET = 9; // halftone setup already issued
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1; // sticky, write one to clear
	localparam int ST_ERR = 2; // sticky, write one to clear

	// refusal causes shown in status bits 11:8
	localparam logic [3:0] CAUSE_NONE = 4'h0;
	localparam logic [3:0] CAUSE_NO_UB = 4'h1;
	localparam logic [3:0] CAUSE_NO_HT = 4'h2;
	localparam logic [3:0] CAUSE_HREM = 4'h3;
	localparam logic [3:0] CAUSE_X_CLIP_OFFSET = 4'h4;
	localparam logic [3:0] CAUSE_Y_CLIP_OFFSET = 4'h5;
	localparam logic [3:0] CAUSE_FW = 4'h6;
	localparam logic [3:0] CAUSE_FH = 4'h7;
	localparam logic [3:0] CAUSE_ORDER = 4'h8;

	// reset values
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_HALF = 16'h0000;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		ORD_PLAIN = 2'b00,
		ORD_HALF = 2'b01,
		ORD_EXP = 2'b10,
		ORD_BAD = 2'b11
	} ubo_order_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LOAD = 3'b001,
		ST_CHECK = 3'b010,
		ST_SEND = 3'b011,
		ST_FINISH = 3'b100
	} ubo_state_t;

endpackage

// >>> ubo_emit_if.sv
// word handshake between the order sequencer and the memory writer
`timescale 1ns/1ps
`default_nettype none

interface ubo_emit_if;
	logic valid; // a list word is offered
	logic ready; // the writer can take it
	logic [31:0] addr; // byte address of the word
	logic [15:0] data; // list word, big-endian byte order
	modport src (output valid, output addr, output data, input ready);
	modport snk (input valid, input addr, input data, output ready);
endinterface

`default_nettype wire

// >>> ubo_word_emit.sv
// writes one display-list word at a time into shared memory
`timescale 1ns/1ps
`default_nettype none

module ubo_word_emit (
	input wire logic clk_i,
	input wire logic nrst_i,
	ubo_emit_if.snk emit,
	output logic [31:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	output logic mem_we_o,
	input wire logic mem_ready_i
);

	// ****************************************
	// holding stage
	// ****************************************
	logic hold; // a word waits for the memory

	// a new word only enters while the stage is empty
	assign emit.ready = !hold;
	assign mem_we_o = hold;

	// hold flag: set on accept, cleared once memory takes it
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			hold <= 1'b0;
		end else if (!hold && emit.valid) begin
			hold <= 1'b1;
		end else if (hold && mem_ready_i) begin
			hold <= 1'b0;
		end
	end

	// address and data are captured and held while waiting
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			mem_addr_o <= ubo_pkg::RST_WORD;
			mem_wdata_o <= ubo_pkg::RST_HALF;
		end else if (!hold && emit.valid) begin
			mem_addr_o <= emit.addr;
			mem_wdata_o <= emit.data;
		end
	end

	// the request stays put until the memory answers
	chk_write_held: assert property (@(posedge clk_i) disable iff (!nrst_i)
		mem_we_o && !mem_ready_i |=> mem_we_o && $stable(mem_addr_o)
		&& $stable(mem_wdata_o))
		else $error("memory write dropped before accepted");

endmodule // ubo_word_emit

`default_nettype wire

// >>> ubo_param_check.sv
// checks an order's parameters before it is placed in the list
`timescale 1ns/1ps
`default_nettype none

module ubo_param_check #(
	parameter logic [15:0] X_MULTIPLIER_SUPPORTED = 16'hFFFF
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [1:0] order_i,
	input wire logic ub_set_i,
	input wire logic ht_set_i,
	input wire logic [15:0] fw_i,
	input wire logic [15:0] fh_i,
	input wire logic [15:0] scale_i,
	input wire logic [15:0] hxr_i,
	input wire logic [15:0] hyr_i,
	input wire logic [15:0] hw_i,
	input wire logic [15:0] hh_i,
	input wire logic [15:0] src_w_i,
	input wire logic [15:0] src_h_i,
	output logic ok_o,
	output logic [3:0] cause_o
);

	// multiplier nibble to scaling factor 1..16
	function automatic logic [4:0] factor(input logic [3:0] mul);
		factor = {1'b0, mul} + 5'h01;
	endfunction

	// ****************************************
	// field split
	// ****************************************
	logic [3:0] x_clip_offset; // left clip bits
	logic [3:0] x_multiplier; // x multiplier
	logic [3:0] y_clip_offset; // top clip scanlines
	logic [3:0] y_multiplier; // y multiplier
	logic [4:0] xfac; // effective x factor
	logic [20:0] fw_max; // widest legal frame
	logic [20:0] fh_max; // tallest legal frame
	logic [3:0] next_cause; // first failing check

	assign x_clip_offset = scale_i[15:12]; // RQ19
	assign x_multiplier = scale_i[11:8];
	assign y_clip_offset = scale_i[7:4]; // RQ21
	assign y_multiplier = scale_i[3:0];

	// an unsupported x multiplier means the device will not scale
	assign xfac = X_MULTIPLIER_SUPPORTED[x_multiplier] ? factor(x_multiplier) : 5'h01;
	assign fw_max = src_w_i * xfac; // RQ15
	assign fh_max = src_h_i * factor(y_multiplier); // RQ15

	// first failure wins, in order of importance
	always_comb begin
		next_cause = ubo_pkg::CAUSE_NONE;
		if (order_i == ubo_pkg::ORD_BAD) begin
			next_cause = ubo_pkg::CAUSE_ORDER;
		end else if (!ub_set_i) begin
			next_cause = ubo_pkg::CAUSE_NO_UB; // RQ3
		end else if (order_i == ubo_pkg::ORD_HALF) begin
			if (!ht_set_i) begin
				next_cause = ubo_pkg::CAUSE_NO_HT; // RQ8
			end else if (hxr_i == 16'h0000 || hxr_i > hw_i
				|| hyr_i == 16'h0000 || hyr_i > hh_i) begin
				next_cause = ubo_pkg::CAUSE_HREM; // RQ9
			end
		end else if (order_i == ubo_pkg::ORD_EXP) begin
			if (x_clip_offset > x_multiplier) begin
				next_cause = ubo_pkg::CAUSE_X_CLIP_OFFSET; // RQ19
			end else if (y_clip_offset > y_multiplier) begin
				next_cause = ubo_pkg::CAUSE_Y_CLIP_OFFSET; // RQ21
			end else if ({5'h00, fw_i} > fw_max) begin
				next_cause = ubo_pkg::CAUSE_FW; // RQ15
			end else if ({5'h00, fh_i} > fh_max) begin
				next_cause = ubo_pkg::CAUSE_FH; // RQ15
			end
		end
	end

	// verdict registered each cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cause_o <= ubo_pkg::CAUSE_NONE;
			ok_o <= 1'b0;
		end else begin
			cause_o <= next_cause;
			ok_o <= (next_cause == ubo_pkg::CAUSE_NONE);
		end
	end

endmodule // ubo_param_check

`default_nettype wire

// >>> ubo_host.sv
// software-driven writer of unbanded transfer orders into a display list
//
// Behaviour
// RQ1: plain order is opcode 22, reserved, fields
// RQ2: device combines source, destination by code
// RQ3: destination setup issued before any transfer
// RQ4: device source warp: width unless setup nonzero
// RQ5: halftone order 23 adds remainders and address
// RQ6: device combines three operands by code
// RQ7: device tiles halftone by wrapping edges
// RQ8: halftone dimensions set before halftone order
// RQ9: remainders within one to halftone size
// RQ10: full size starts top left corner
// RQ11: addresses point at upper left corners
// RQ12: expanded order 26 with warp, scale bytes
// RQ13: device expands source then combines
// RQ14: expanded frame stays inside destination
// RQ15: frame no larger than scaled source
// RQ16: device steps source by order's warp
// RQ17: device ignores stored source warp here
// RQ18: x multiplier low nibble, unsupported unscaled
// RQ19: x offset high nibble, within multiplier
// RQ20: y multiplier low nibble, any value
// RQ21: y offset high nibble, within multiplier
// RQ22: device holds supported x factor table
// RQ23: list pointer moves past finished order
`timescale 1ns/1ps
`default_nettype none

module ubo_host #(
	parameter logic [15:0] X_MULTIPLIER_SUPPORTED = 16'hFFFF
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic [31:0] mem_addr_o,
	output logic [15:0] mem_wdata_o,
	output logic mem_we_o,
	input wire logic mem_ready_i
);

	// ****************************************
	// software registers
	// ****************************************
	ubo_pkg::ubo_order_t order; // order kind to build
	logic ub_set; // destination setup issued
	logic ht_set; // halftone setup issued
	logic [31:0] dest_addr; // destination bit address
	logic [15:0] frame_width;
	logic [15:0] frame_height;
	logic [31:0] src_addr; // source bit address
	logic [15:0] src_warp; // unexpanded source warp
	logic [15:0] scale; // x clip:mul, y clip:mul
	logic [15:0] halftone_x_remainder;
	logic [15:0] halftone_y_remainder;
	logic [31:0] halftone_addr; // halftone bit address
	logic [15:0] halftone_width;
	logic [15:0] halftone_height;
	logic [15:0] src_width; // unexpanded source size
	logic [15:0] src_height;
	logic [31:0] list_ptr; // next free list byte
	logic done; // sticky order written
	logic err; // sticky order refused
	logic [3:0] err_cause; // cause of last refusal

	// ****************************************
	// sequencer state
	// ****************************************
	ubo_pkg::ubo_state_t state; // sequencer state
	logic [3:0] idx; // word being offered
	logic [3:0] nwords; // words in this order
	logic chk_ok; // checker verdict
	logic [3:0] chk_cause; // checker cause
	logic [15:0] word; // word offered now

	// ****************************************
	// bus decode
	// ****************************************
	logic wr_acc; // write access phase
	logic go; // start request
	logic mapped; // address hits a register
	logic [31:0] next_rdata; // read mux

	assign pready_o = 1'b1; // zero-wait slave
	assign wr_acc = psel_i && penable_i && pwrite_i;
	assign go = wr_acc && paddr_i == ubo_pkg::REG_CTRL
		&& pwdata_i[ubo_pkg::CTRL_GO];
	assign pslverr_o = psel_i && penable_i && !mapped;

	// read mux and decode
	always_comb begin
		mapped = 1'b1;
		next_rdata = ubo_pkg::RST_WORD;
		case (paddr_i)
			ubo_pkg::REG_CTRL: next_rdata = {22'h00_0000, ht_set,
				ub_set, 6'h00, order};
			ubo_pkg::REG_STATUS: next_rdata = {20'h0_0000, err_cause,
				5'h00, err, done, state != ubo_pkg::ST_IDLE};
			ubo_pkg::REG_DEST: next_rdata = dest_addr;
			ubo_pkg::REG_FRAME: next_rdata = {frame_width, frame_height};
			ubo_pkg::REG_SRC: next_rdata = src_addr;
			ubo_pkg::REG_SWARP: next_rdata = {16'h0000, src_warp};
			ubo_pkg::REG_SCALE: next_rdata = {16'h0000, scale};
			ubo_pkg::REG_HREM: next_rdata = {halftone_x_remainder,
				halftone_y_remainder};
			ubo_pkg::REG_HADDR: next_rdata = halftone_addr;
			ubo_pkg::REG_HDIM: next_rdata = {halftone_width,
				halftone_height};
			ubo_pkg::REG_SDIM: next_rdata = {src_width, src_height};
			ubo_pkg::REG_LPTR: next_rdata = list_ptr;
			default: mapped = 1'b0;
		endcase
	end

	// read data captured in the setup cycle, shown in access
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			prdata_o <= ubo_pkg::RST_WORD;
		end else if (psel_i && !penable_i && !pwrite_i) begin
			prdata_o <= next_rdata;
		end
	end

	// parameter registers; writes while busy are ignored
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			order <= ubo_pkg::ORD_PLAIN;
			ub_set <= 1'b0;
			ht_set <= 1'b0;
			dest_addr <= ubo_pkg::RST_WORD;
			frame_width <= ubo_pkg::RST_HALF;
			frame_height <= ubo_pkg::RST_HALF;
			src_addr <= ubo_pkg::RST_WORD;
			src_warp <= ubo_pkg::RST_HALF;
			scale <= ubo_pkg::RST_HALF;
			halftone_x_remainder <= ubo_pkg::RST_HALF;
			halftone_y_remainder <= ubo_pkg::RST_HALF;
			halftone_addr <= ubo_pkg::RST_WORD;
			halftone_width <= ubo_pkg::RST_HALF;
			halftone_height <= ubo_pkg::RST_HALF;
			src_width <= ubo_pkg::RST_HALF;
			src_height <= ubo_pkg::RST_HALF;
		end else if (wr_acc && state == ubo_pkg::ST_IDLE) begin
			case (paddr_i)
				ubo_pkg::REG_CTRL: begin
					order <= ubo_pkg::ubo_order_t'(pwdata_i[1:0]);
					ub_set <= pwdata_i[ubo_pkg::CTRL_UBSET];
					ht_set <= pwdata_i[ubo_pkg::CTRL_HTSET];
				end
				ubo_pkg::REG_DEST: dest_addr <= pwdata_i; // RQ11
				ubo_pkg::REG_FRAME: begin
					frame_width <= pwdata_i[31:16];
					frame_height <= pwdata_i[15:0];
				end
				ubo_pkg::REG_SRC: src_addr <= pwdata_i;
				ubo_pkg::REG_SWARP: src_warp <= pwdata_i[15:0];
				ubo_pkg::REG_SCALE: scale <= pwdata_i[15:0];
				ubo_pkg::REG_HREM: begin
					halftone_x_remainder <= pwdata_i[31:16]; // RQ10
					halftone_y_remainder <= pwdata_i[15:0];
				end
				ubo_pkg::REG_HADDR: halftone_addr <= pwdata_i;
				ubo_pkg::REG_HDIM: begin
					halftone_width <= pwdata_i[31:16];
					halftone_height <= pwdata_i[15:0];
				end
				ubo_pkg::REG_SDIM: begin
					src_width <= pwdata_i[31:16];
					src_height <= pwdata_i[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// parameter check
	// ****************************************
	ubo_param_check #(
		.X_MULTIPLIER_SUPPORTED(X_MULTIPLIER_SUPPORTED)
	) u_check (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.order_i(order),
		.ub_set_i(ub_set),
		.ht_set_i(ht_set),
		.fw_i(frame_width),
		.fh_i(frame_height),
		.scale_i(scale),
		.hxr_i(halftone_x_remainder),
		.hyr_i(halftone_y_remainder),
		.hw_i(halftone_width),
		.hh_i(halftone_height),
		.src_w_i(src_width),
		.src_h_i(src_height),
		.ok_o(chk_ok),
		.cause_o(chk_cause)
	);

	// ****************************************
	// list word assembly
	// ****************************************
	// word i of the current order, big-endian fields
	function automatic logic [15:0] word_at(input logic [3:0] i);
		logic [7:0] op;
		op = ubo_pkg::OP_RSVD;
		case (order)
			ubo_pkg::ORD_PLAIN: op = ubo_pkg::OP_PLAIN; // RQ1
			ubo_pkg::ORD_HALF: op = ubo_pkg::OP_HALF; // RQ5
			ubo_pkg::ORD_EXP: op = ubo_pkg::OP_EXP; // RQ12
			default: op = ubo_pkg::OP_RSVD;
		endcase
		case (i)
			4'h0: word_at = {op, ubo_pkg::OP_RSVD};
			4'h1: word_at = dest_addr[31:16];
			4'h2: word_at = dest_addr[15:0];
			4'h3: word_at = frame_width; // RQ14
			4'h4: word_at = frame_height;
			4'h5: word_at = src_addr[31:16];
			4'h6: word_at = src_addr[15:0];
			4'h7: word_at = (order == ubo_pkg::ORD_EXP) ? src_warp
				: halftone_x_remainder; // RQ12
			4'h8: word_at = (order == ubo_pkg::ORD_EXP) ? scale
				: halftone_y_remainder; // RQ12
			4'h9: word_at = halftone_addr[31:16]; // RQ5
			4'hA: word_at = halftone_addr[15:0];
			default: word_at = ubo_pkg::RST_HALF;
		endcase
	endfunction

	// word count by order kind
	always_comb begin
		case (order)
			ubo_pkg::ORD_HALF: nwords = ubo_pkg::WORDS_HALF;
			ubo_pkg::ORD_EXP: nwords = ubo_pkg::WORDS_EXP;
			default: nwords = ubo_pkg::WORDS_PLAIN;
		endcase
	end

	always_comb begin
		word = word_at(idx);
	end

	ubo_emit_if emit_bus ();

	assign emit_bus.valid = (state == ubo_pkg::ST_SEND);
	assign emit_bus.data = word;
	assign emit_bus.addr = list_ptr + {27'h000_0000, idx, 1'b0};

	ubo_word_emit u_emit (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.emit(emit_bus.snk),
		.mem_addr_o(mem_addr_o),
		.mem_wdata_o(mem_wdata_o),
		.mem_we_o(mem_we_o),
		.mem_ready_i(mem_ready_i)
	);

	// ****************************************
	// sequencer
	// ****************************************
	// idle -> load -> check -> send words -> finish
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			state <= ubo_pkg::ST_IDLE;
			idx <= 4'h0;
		end else begin
			case (state)
				ubo_pkg::ST_IDLE: if (go) begin
					state <= ubo_pkg::ST_LOAD;
					idx <= 4'h0;
				end
				// checker registers the newly written order kind
				ubo_pkg::ST_LOAD: state <= ubo_pkg::ST_CHECK;
				ubo_pkg::ST_CHECK: if (chk_ok) begin
					state <= ubo_pkg::ST_SEND; // RQ3
				end else begin
					state <= ubo_pkg::ST_IDLE;
				end
				ubo_pkg::ST_SEND: if (emit_bus.ready) begin
					idx <= idx + 4'h1;
					if (idx == nwords - 4'h1) begin
						state <= ubo_pkg::ST_FINISH;
					end
				end
				// wait for the last word to reach memory
				ubo_pkg::ST_FINISH: if (emit_bus.ready) begin
					state <= ubo_pkg::ST_IDLE;
				end
				default: state <= ubo_pkg::ST_IDLE;
			endcase
		end
	end

	// list pointer: set by software, advanced past each written order
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			list_ptr <= ubo_pkg::RST_WORD;
		end else if (state == ubo_pkg::ST_FINISH && emit_bus.ready) begin
			list_ptr <= list_ptr + {27'h000_0000, nwords, 1'b0}; // RQ23
		end else if (wr_acc && state == ubo_pkg::ST_IDLE
			&& paddr_i == ubo_pkg::REG_LPTR) begin
			list_ptr <= {pwdata_i[31:1], 1'b0};
		end
	end

	// sticky flags: a new event wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			done <= 1'b0;
			err <= 1'b0;
			err_cause <= ubo_pkg::CAUSE_NONE;
		end else begin
			if (state == ubo_pkg::ST_FINISH && emit_bus.ready) begin
				done <= 1'b1;
			end else if (wr_acc && paddr_i == ubo_pkg::REG_STATUS
				&& pwdata_i[ubo_pkg::ST_DONE]) begin
				done <= 1'b0;
			end
			if (state == ubo_pkg::ST_CHECK && !chk_ok) begin
				err <= 1'b1;
				err_cause <= chk_cause;
			end else if (wr_acc && paddr_i == ubo_pkg::REG_STATUS
				&& pwdata_i[ubo_pkg::ST_ERR]) begin
				err <= 1'b0;
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_first_word;
		state == ubo_pkg::ST_SEND && idx == 4'h0;
	endsequence

	sequence s_last_taken;
		state == ubo_pkg::ST_FINISH && emit_bus.ready;
	endsequence

	chk_plain_opcode: assert property ( // RQ1
		s_first_word and order == ubo_pkg::ORD_PLAIN
		|-> word == 16'h2200)
		else $error("plain order opcode word wrong");

	chk_half_opcode: assert property ( // RQ5
		s_first_word and order == ubo_pkg::ORD_HALF
		|-> word == 16'h2300)
		else $error("halftone order opcode word wrong");

	chk_exp_opcode: assert property ( // RQ12
		s_first_word and order == ubo_pkg::ORD_EXP
		|-> word == 16'h2600)
		else $error("expanded order opcode word wrong");

	chk_setup_gate: assert property ( // RQ3
		state == ubo_pkg::ST_CHECK && !ub_set
		|=> state == ubo_pkg::ST_IDLE && err)
		else $error("order sent without destination setup");

	chk_halftone_gate: assert property ( // RQ8
		state == ubo_pkg::ST_SEND && order == ubo_pkg::ORD_HALF
		|-> ht_set)
		else $error("halftone order sent without setup");

	chk_rem_range: assert property ( // RQ9
		state == ubo_pkg::ST_SEND && order == ubo_pkg::ORD_HALF
		|-> halftone_x_remainder != 16'h0000
		&& halftone_x_remainder <= halftone_width
		&& halftone_y_remainder != 16'h0000
		&& halftone_y_remainder <= halftone_height)
		else $error("halftone remainder out of range");

	chk_clip_range: assert property ( // RQ19
		state == ubo_pkg::ST_SEND && order == ubo_pkg::ORD_EXP
		|-> scale[15:12] <= scale[11:8])
		else $error("x clip beyond multiplier");

	chk_yclip_range: assert property ( // RQ21
		state == ubo_pkg::ST_SEND && order == ubo_pkg::ORD_EXP
		|-> scale[7:4] <= scale[3:0])
		else $error("y clip beyond multiplier");

	chk_list_advance: assert property ( // RQ23
		s_last_taken |=> list_ptr == $past(list_ptr)
		+ {27'h000_0000, $past(nwords), 1'b0} && done)
		else $error("list pointer not moved past order");

endmodule // ubo_host

`default_nettype wire

// >>> ubo_mem_model.sv
// shared list memory that takes words from the order writer
`timescale 1ns/1ps
`default_nettype none

module ubo_mem_model (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic slow_i,
	input wire logic [31:0] mem_addr_i,
	input wire logic [15:0] mem_wdata_i,
	input wire logic mem_we_i,
	output logic mem_ready_o
);
	logic [15:0] words [0:127]; // list words, indexed by word address
	logic tog; // stall phase in slow mode

	// slow mode refuses every other cycle; a write held on a refused cycle waits one more
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			tog <= 1'b0;
		end else begin
			tog <= !tog;
		end
	end
	assign mem_ready_o = !slow_i | tog;

	// keep words in list order for the fetcher
	always_ff @(posedge clk_i) begin
		if (mem_we_i && mem_ready_o) begin
			words[mem_addr_i[7:1]] <= mem_wdata_i;
		end
	end
endmodule // ubo_mem_model

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the unbanded transfer order writer
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, mem_addr;
	logic pready, pslverr, mem_we, mem_ready, last_err;
	logic [15:0] mem_wdata;
	logic [15:0] ew [0:10]; // expected list words
	int n_fail = 0, n_compared = 0;

	ubo_host dut (.clk_i(clk_i), .nrst_i(nrst_i), .paddr_i(paddr),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .mem_addr_o(mem_addr),
		.mem_wdata_o(mem_wdata), .mem_we_o(mem_we),
		.mem_ready_i(mem_ready));
	ubo_mem_model u_mem (.clk_i(clk_i), .nrst_i(nrst_i), .slow_i(slow),
		.mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata),
		.mem_we_i(mem_we), .mem_ready_o(mem_ready));

	initial begin
		forever #12.5 clk_i = !clk_i;
	end

	task automatic complete_run;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	// one apb transfer: setup, then access until pready
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			n_fail++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		apb(1'b0, a, 32'h0000_0000, r);
		chk("register", e, r);
	endtask

	// start an order and poll status until it settles
	task automatic run(input logic [31:0] c);
		logic [31:0] r;
		int n;
		wr(8'h00, c | 32'h0000_0010);
		n = 0;
		do begin
			apb(1'b0, 8'h04, 32'h0000_0000, r);
			n++;
		end while (!(r[0] === 1'b0 && (r[1] | r[2]) === 1'b1) && n < 60);
		if (n >= 60) begin
			n_fail++;
			complete_run();
		end
	endtask

	task automatic listchk(input int b, input int cnt);
		for (int i = 0; i < cnt; i++) chk("list word", {16'h0000, ew[i]},
			{16'h0000, u_mem.words[b + i]});
	endtask

	// refusal cases: control, scale, expected cause
	logic [31:0] rc [0:6] = '{32'h0000_0000, 32'h0000_0101, 32'h0000_0103,
		32'h0000_0102, 32'h0000_0102, 32'h0000_0102, 32'h0000_0102};
	logic [15:0] rs [0:6] = '{16'h2311, 16'h2311, 16'h2311, 16'h4311,
		16'h2321, 16'h0111, 16'h2300};
	logic [3:0] rz [0:6] = '{4'h1, 4'h2, 4'h8, 4'h4, 4'h5, 4'h6, 4'h7};

	initial begin
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(8'h04, 32'h0000_0000);
		rd(8'hF0, 32'h0000_0000);
		chk("slverr", 32'h0000_0001, {31'h0, last_err});
		// plain order, memory always ready
		wr(8'h08, 32'h1234_5678);
		wr(8'h0C, 32'h0020_0010);
		wr(8'h10, 32'h0AB0_0CD0);
		wr(8'h14, 32'h0000_0010);
		wr(8'h18, 32'h0000_2311);
		wr(8'h28, 32'h0008_0008);
		run(32'h0000_0100);
		rd(8'h04, 32'h0000_0002);
		ew = '{16'h2200, 16'h1234, 16'h5678, 16'h0020, 16'h0010,
			16'h0AB0, 16'h0CD0, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
		listchk(0, 7);
		rd(8'h2C, 32'h0000_000E);
		wr(8'h04, 32'h0000_0006);
		// halftone order with a stalling memory
		slow <= 1'b1;
		wr(8'h1C, 32'h0004_0001);
		wr(8'h20, 32'h0000_0100);
		wr(8'h24, 32'h0004_0004);
		run(32'h0000_0301);
		rd(8'h04, 32'h0000_0002);
		ew = '{16'h2300, 16'h1234, 16'h5678, 16'h0020, 16'h0010,
			16'h0AB0, 16'h0CD0, 16'h0004, 16'h0001, 16'h0000, 16'h0100};
		listchk(7, 11);
		rd(8'h2C, 32'h0000_0024);
		wr(8'h04, 32'h0000_0006);
		// expanded order: warp then both scale bytes
		run(32'h0000_0102);
		rd(8'h04, 32'h0000_0002);
		ew = '{16'h2600, 16'h1234, 16'h5678, 16'h0020, 16'h0010,
			16'h0AB0, 16'h0CD0, 16'h0010, 16'h2311, 16'h0000,
			16'h0000};
		listchk(18, 9);
		rd(8'h2C, 32'h0000_0036);
		wr(8'h04, 32'h0000_0006);
		// refused orders leave error, cause and no list words
		for (int i = 0; i < 7; i++) begin
			wr(8'h18, {16'h0000, rs[i]});
			run(rc[i]);
			rd(8'h04, {20'h0_0000, rz[i], 8'h04});
			wr(8'h04, 32'h0000_0006);
		end
		// halftone remainder beyond the halftone width is refused
		wr(8'h1C, 32'h0005_0001);
		run(32'h0000_0301);
		rd(8'h04, 32'h0000_0304);
		wr(8'h04, 32'h0000_0006);
		rd(8'h2C, 32'h0000_0036);
		// a reset while idle returns pointer and setup flags to zero
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(8'h2C, 32'h0000_0000);
		rd(8'h00, 32'h0000_0000);
		complete_run();
	end
endmodule // tb_top

`default_nettype wire
